// [core/dac_clk_monitor.sv]
`timescale 1ns/1ps
`include "dac_regs_cfg.svh"

module dac_clk_monitor #(
	parameter int GONE_BASE = `CLK_GONE_BASE
) (
	input  wire logic                 clk_in,
	input  wire logic                 srst_in,
	input  wire logic                 conv_clk_tick_in,
	input  wire logic [`INTERP_W-1:0] interp_in,
	output logic                      gone_out
);

	// Largest base shifted by the largest setting must fit the counter
	if (GONE_BASE < 1 || GONE_BASE > 4096) begin : g_bad_base
		$error("GONE_BASE out of range");
	end

	logic [`GONE_CNT_W-1:0] cnt;
	wire  [`GONE_CNT_W-1:0] limit;
	wire                    at_limit;

	// Higher interpolation slows the tick, so the wait scales with it
	assign limit    = `GONE_CNT_W'(GONE_BASE) << interp_in;
	assign at_limit = (cnt >= limit - `GONE_CNT_W'(1));

	// (RULE_14) quiet cycle count
	always_ff @(posedge clk_in) begin
		if (srst_in || conv_clk_tick_in) begin
			cnt      <= '0;
			gone_out <= 1'b0;
		end else if (at_limit) begin
			gone_out <= 1'b1;
		end else begin
			cnt <= cnt + `GONE_CNT_W'(1);
		end
	end

	AST_TICK_CLEARS: assert property ( // RULE_14
		@(posedge clk_in) disable iff (srst_in)
		conv_clk_tick_in |=> !gone_out)
		else $error("clock monitor still flags gone after a tick");

endmodule : dac_clk_monitor

// [core/dac_input_regs.sv]
`timescale 1ns/1ps
`include "dac_regs_cfg.svh"

// How it works
// (RULE_01) Fourteen lane enables, all set after reset
// (RULE_02) Host clears low seven in 7-bit mode
// (RULE_03) Bits 15:13 trim upper or bus A data
// (RULE_04) Bits 12:10 trim sync or bus A clock
// (RULE_05) Bits 9:7 trim lower or bus B data
// (RULE_06) Bits 6:4 trim data or bus B clock
// (RULE_07) Bit 3 selects external reference
// (RULE_08) Bit 0 selects alternate FIFO clock pair
// (RULE_09) Host keeps bit 0 clear in full-word mode
// (RULE_10) Pattern mismatch on bit n sets result n
// (RULE_11) All-zero write pointer sets bit 15
// (RULE_12) Host resyncs after stuck pointer alarm
// (RULE_13) Pointer status coded 000/001/01X/1XX
// (RULE_14) Stopped converter clock sets bit 7
// (RULE_15) Status cleared by write, kept over reset
// (RULE_16) Pattern checker runs only when enabled
// (RULE_17) Pointer alarms gated by own enables
module dac_input_regs #(
	parameter int LANES      = `NUM_LANES,
	parameter int PATT_DEPTH = `PATT_DEPTH,
	parameter int GONE_BASE  = `CLK_GONE_BASE
) (
	input  wire logic                                clk_in,
	input  wire logic                                srst_in,
	input  wire dac_regs_pkg::reg_req_t              reg_req_in,
	output logic [`REG_W-1:0]                        reg_rdata_out,
	input  wire logic                                iotest_enable_in,
	input  wire logic                                sync_in,
	input  wire logic                                sample_valid_in,
	input  wire logic [LANES-1:0]                    sample_in,
	input  wire logic [PATT_DEPTH-1:0][LANES-1:0]    pattern_in,
	input  wire logic [`WR_PTR_W-1:0]                wr_ptr_shift_in,
	input  wire dac_regs_pkg::ptr_flags_t            ptr_flags_in,
	input  wire logic                                two_apart_alarm_enable_in,
	input  wire logic                                one_apart_alarm_enable_in,
	input  wire logic                                collision_alarm_enable_in,
	input  wire logic                                conv_clk_tick_in,
	input  wire logic [`INTERP_W-1:0]                interp_in,
	output logic [LANES-1:0]                         lane_enable_out,
	output dac_regs_pkg::trim_t                      trim_out,
	output logic                                     ext_ref_out,
	output logic                                     alt_clk_sel_out
);
	import dac_regs_pkg::*;

	localparam int IDX_W = $clog2(PATT_DEPTH);

	if (LANES < 1 || LANES > `NUM_LANES) begin : g_bad_lanes
		$error("LANES must be 1..14");
	end
	// The sample index wraps by overflow, so the depth is a power of two
	if (PATT_DEPTH < 2 || (1 << IDX_W) != PATT_DEPTH) begin : g_bad_depth
		$error("PATT_DEPTH must be a power of two");
	end

	// Write-to-clear: a written 0 clears, set wins over the clear
	function automatic logic [`REG_W-1:0] wc_next(
		input logic [`REG_W-1:0] old,
		input logic [`REG_W-1:0] wdata,
		input logic              wr,
		input logic [`REG_W-1:0] set,
		input logic [`REG_W-1:0] mask
	);
		wc_next = ((wr ? (old & wdata) : old) | set) & mask;
	endfunction : wc_next

	logic [`REG_W-1:0] lane_reg;
	logic [`REG_W-1:0] trim_reg;
	logic [`REG_W-1:0] patt_reg;
	logic [`REG_W-1:0] alarm_reg;
	logic [IDX_W-1:0]  idx;
	logic              clk_gone;

	wire wr_lane  = reg_req_in.wr && reg_req_in.addr == `ADDR_LANE_EN;
	wire wr_trim  = reg_req_in.wr && reg_req_in.addr == `ADDR_TRIM;
	wire wr_patt  = reg_req_in.wr && reg_req_in.addr == `ADDR_PATT;
	wire wr_alarm = reg_req_in.wr && reg_req_in.addr == `ADDR_ALARM;

	wire [`REG_W-1:0] rd_mux =
		(reg_req_in.addr == `ADDR_LANE_EN) ? lane_reg :
		(reg_req_in.addr == `ADDR_TRIM)    ? trim_reg :
		(reg_req_in.addr == `ADDR_PATT)    ? patt_reg :
		(reg_req_in.addr == `ADDR_ALARM)   ? alarm_reg : `RDATA_RST;

	// (RULE_16) checker idles while disabled
	wire             run     = iotest_enable_in && sample_valid_in;
	// Sample 0 lines up with the sync
	wire [IDX_W-1:0] cur_idx = sync_in ? '0 : idx;
	wire [LANES-1:0] fail    = sample_in ^ pattern_in[cur_idx];
	// (RULE_10) failing bit positions
	wire [`REG_W-1:0] patt_set =
		run ? `REG_W'(fail) : `REG_W'(0);

	// (RULE_13) priority coding of enabled pointer flags
	// (RULE_17) each flag only with its enable
	wire [2:0] ptr_code =
		(ptr_flags_in.collision && collision_alarm_enable_in) ? `PTR_COLL :
		(ptr_flags_in.one_apart && one_apart_alarm_enable_in) ? `PTR_ONE :
		(ptr_flags_in.two_apart && two_apart_alarm_enable_in) ? `PTR_TWO :
		`PTR_OK;

	// (RULE_11) stuck shift-register pointer
	wire stuck = (wr_ptr_shift_in == '0);

	wire [`REG_W-1:0] alarm_set =
		(`REG_W'(stuck)    << `STUCK_BIT) |
		(`REG_W'(ptr_code) << `PTR_LO) |
		(`REG_W'(clk_gone) << `CLKGONE_BIT);

	dac_clk_monitor #(
		.GONE_BASE (GONE_BASE)
	) u_clk_monitor (
		.clk_in           (clk_in),
		.srst_in          (srst_in),
		.conv_clk_tick_in (conv_clk_tick_in),
		.interp_in        (interp_in),
		.gone_out         (clk_gone)
	);

	// (RULE_01) lane enables and trims
	always_ff @(posedge clk_in) begin
		if (srst_in) begin
			lane_reg      <= `LANE_EN_RST;
			trim_reg      <= `TRIM_RST;
			reg_rdata_out <= `RDATA_RST;
		end else begin
			if (wr_lane)
				lane_reg <= reg_req_in.wdata & `LANE_EN_MASK;
			if (wr_trim)
				trim_reg <= reg_req_in.wdata & `TRIM_MASK;
			reg_rdata_out <= rd_mux;
		end
	end

	// (RULE_15) status has no reset on purpose
	always_ff @(posedge clk_in) begin
		patt_reg  <= wc_next(patt_reg, reg_req_in.wdata, wr_patt,
			patt_set, `PATT_MASK);
		alarm_reg <= wc_next(alarm_reg, reg_req_in.wdata, wr_alarm,
			alarm_set, `ALARM_MASK);
	end

	// (RULE_16) index frozen while disabled saves toggling
	always_ff @(posedge clk_in) begin
		if (srst_in)
			idx <= '0;
		else if (run)
			idx <= cur_idx + IDX_W'(1);
		else if (sync_in && iotest_enable_in)
			idx <= '0;
	end

	// (RULE_03) (RULE_04) (RULE_05) (RULE_06) trim fields out
	assign lane_enable_out = lane_reg[LANES-1:0];
	assign trim_out.data_a = trim_reg[`DLY_DA_HI:`DLY_DA_LO];
	assign trim_out.clk_a  = trim_reg[`DLY_CA_HI:`DLY_CA_LO];
	assign trim_out.data_b = trim_reg[`DLY_DB_HI:`DLY_DB_LO];
	assign trim_out.clk_b  = trim_reg[`DLY_CB_HI:`DLY_CB_LO];
	// (RULE_07) (RULE_08) reference and clock-pair select
	assign ext_ref_out     = trim_reg[`EXTREF_BIT];
	assign alt_clk_sel_out = trim_reg[`ALTCLK_BIT];

	AST_LANE_RESET: assert property ( // RULE_01
		@(posedge clk_in) srst_in |=> lane_enable_out == {LANES{1'b1}})
		else $error("lane enables not all set after reset");

	AST_DATA_A: assert property ( // RULE_03
		@(posedge clk_in) disable iff (srst_in)
		wr_trim |=> trim_out.data_a ==
			$past(reg_req_in.wdata[`DLY_DA_HI:`DLY_DA_LO]))
		else $error("bus A data trim not taken");

	AST_CLK_A: assert property ( // RULE_04
		@(posedge clk_in) disable iff (srst_in)
		wr_trim |=> trim_out.clk_a ==
			$past(reg_req_in.wdata[`DLY_CA_HI:`DLY_CA_LO]))
		else $error("bus A clock trim not taken");

	AST_DATA_B: assert property ( // RULE_05
		@(posedge clk_in) disable iff (srst_in)
		wr_trim |=> trim_out.data_b ==
			$past(reg_req_in.wdata[`DLY_DB_HI:`DLY_DB_LO]))
		else $error("bus B data trim not taken");

	AST_CLK_B: assert property ( // RULE_06
		@(posedge clk_in) srst_in |=> trim_out.clk_b == '0)
		else $error("bus B clock trim not zero after reset");

	AST_EXTREF: assert property ( // RULE_07
		@(posedge clk_in) srst_in |=> !ext_ref_out)
		else $error("external reference selected after reset");

	AST_ALTCLK: assert property ( // RULE_08
		@(posedge clk_in) disable iff (srst_in)
		wr_trim |=> alt_clk_sel_out ==
			$past(reg_req_in.wdata[`ALTCLK_BIT]))
		else $error("clock pair select not taken");

	AST_PATT_FAIL: assert property ( // RULE_10
		@(posedge clk_in) disable iff (srst_in)
		run |=> (patt_reg[LANES-1:0] & $past(fail)) == $past(fail))
		else $error("mismatching bit not recorded");

	AST_STUCK: assert property ( // RULE_11
		@(posedge clk_in) disable iff (srst_in)
		stuck |=> alarm_reg[`STUCK_BIT])
		else $error("stuck pointer alarm missing");

	AST_COLL: assert property ( // RULE_13
		@(posedge clk_in) disable iff (srst_in)
		ptr_flags_in.collision && collision_alarm_enable_in
		|=> alarm_reg[`PTR_HI])
		else $error("collision not coded in top bit");

	AST_GONE: assert property ( // RULE_14
		@(posedge clk_in) disable iff (srst_in)
		clk_gone |=> alarm_reg[`CLKGONE_BIT])
		else $error("clock gone alarm missing");

	AST_HOLD: assert property ( // RULE_15
		@(posedge clk_in) disable iff (srst_in)
		alarm_reg[`STUCK_BIT] && !wr_alarm |=> alarm_reg[`STUCK_BIT])
		else $error("alarm dropped without a write");

	AST_GATED: assert property ( // RULE_16
		@(posedge clk_in) disable iff (srst_in)
		!iotest_enable_in && !wr_patt |=> $stable(idx) && $stable(patt_reg))
		else $error("checker active while disabled");

	AST_MASKED: assert property ( // RULE_17
		@(posedge clk_in) disable iff (srst_in)
		!collision_alarm_enable_in && !alarm_reg[`PTR_HI]
		|=> !alarm_reg[`PTR_HI])
		else $error("masked collision reported");

	COV_PATT: cover property (@(posedge clk_in) run && fail != '0);
	COV_STUCK_CLR: cover property (@(posedge clk_in)
		alarm_reg[`STUCK_BIT] && wr_alarm ##1 !alarm_reg[`STUCK_BIT]);
	COV_GONE: cover property (@(posedge clk_in) $rose(clk_gone));
	COV_ONE: cover property (@(posedge clk_in) ptr_code == `PTR_ONE);

endmodule : dac_input_regs

// [core/dac_regs_cfg.svh]
`ifndef DAC_REGS_CFG_SVH
`define DAC_REGS_CFG_SVH

// Register word indices on the serial register port
`define ADDR_W          7
`define ADDR_LANE_EN    7'h02
`define ADDR_TRIM       7'h03
`define ADDR_PATT       7'h04
`define ADDR_ALARM      7'h05

`define REG_W           16
`define NUM_LANES       14
`define LANE_EN_RST     16'h3fff
`define TRIM_RST        16'h0000
`define RDATA_RST       16'h0000

// Bits that exist; everything else reads as zero
`define LANE_EN_MASK    16'h3fff
`define TRIM_MASK       16'hfff9
`define PATT_MASK       16'h3fff
`define ALARM_MASK      16'hb880

// Trim and select field positions
`define DLY_DA_HI       15
`define DLY_DA_LO       13
`define DLY_CA_HI       12
`define DLY_CA_LO       10
`define DLY_DB_HI       9
`define DLY_DB_LO       7
`define DLY_CB_HI       6
`define DLY_CB_LO       4
`define EXTREF_BIT      3
`define ALTCLK_BIT      0

// Alarm field positions and pointer status codes
`define STUCK_BIT       15
`define PTR_HI          13
`define PTR_LO          11
`define CLKGONE_BIT     7
`define PTR_OK          3'h0
`define PTR_TWO         3'h1
`define PTR_ONE         3'h2
`define PTR_COLL        3'h4

`define PATT_DEPTH      8
`define WR_PTR_W        8
`define INTERP_W        2
`define GONE_CNT_W      16
`define CLK_GONE_BASE   16

`endif

// [core/dac_regs_pkg.sv]
`include "dac_regs_cfg.svh"

package dac_regs_pkg;

	typedef struct packed {
		logic                    wr;
		logic [`ADDR_W-1:0]      addr;
		logic [`REG_W-1:0]       wdata;
	} reg_req_t;

	typedef struct packed {
		logic [2:0] data_a;
		logic [2:0] clk_a;
		logic [2:0] data_b;
		logic [2:0] clk_b;
	} trim_t;

	typedef struct packed {
		logic collision;
		logic one_apart;
		logic two_apart;
	} ptr_flags_t;

endpackage : dac_regs_pkg

// [dv/dac_host_model.sv]
`timescale 1ns/1ps
`include "dac_regs_cfg.svh"

module dac_host_model (
	input  wire logic              clk_in,
	input  wire logic [15:0]       rdata_in,
	output dac_regs_pkg::reg_req_t req_out
);
	import dac_regs_pkg::*;

	initial req_out = '0;

	// Released data lines show the inverse word, never the stale one
	task automatic write_word(input logic [6:0] a, input logic [15:0] d);
		@(posedge clk_in);
		#1;
		req_out.wr = 1'b1;
		req_out.addr = a;
		req_out.wdata = d;
		@(posedge clk_in);
		#1;
		req_out.wr = 1'b0;
		req_out.wdata = ~d;
	endtask : write_word

	task automatic read_word(input logic [6:0] a, output logic [15:0] d);
		@(posedge clk_in);
		#1;
		req_out.addr = a;
		@(posedge clk_in);
		#1;
		d = rdata_in;
	endtask : read_word
endmodule : dac_host_model

// [dv/dac_input_regs_tb.sv]
`timescale 1ns/1ps
`include "dac_regs_cfg.svh"

module dac_input_regs_tb;
	import dac_regs_pkg::*;
	logic             clk_in = 1'b0;
	logic             srst_in = 1'b1;
	reg_req_t         req;
	logic [15:0]      rdata;
	logic             iotest_enable_in = 1'b0;
	logic             sync_in = 1'b0;
	logic             sample_valid_in = 1'b0;
	logic [13:0]      sample_in = '0;
	logic [7:0][13:0] pat;
	logic [7:0]       wr_ptr_shift_in = 8'h01;
	ptr_flags_t       ptr_flags_in = '0;
	logic [2:0]       ena = 3'h7;
	logic             tick = 1'b1;
	logic [1:0]       interp_in = 2'h1;
	logic [13:0]      lane_en;
	trim_t            trim;
	logic             ext_ref;
	logic             alt_clk;
	int               n_errors = 0;
	int               checks = 0;
	logic [15:0]      tv [3] = '{16'hffff, 16'h2009, 16'h5a52};

	always #5 clk_in = ~clk_in;

	dac_host_model u_dac_host_model (
		.clk_in   (clk_in),
		.rdata_in (rdata),
		.req_out  (req)
	);

	dac_input_regs #(.GONE_BASE(2)) u_dac_input_regs (
		.clk_in                    (clk_in),
		.srst_in                   (srst_in),
		.reg_req_in                (req),
		.reg_rdata_out             (rdata),
		.iotest_enable_in          (iotest_enable_in),
		.sync_in                   (sync_in),
		.sample_valid_in           (sample_valid_in),
		.sample_in                 (sample_in),
		.pattern_in                (pat),
		.wr_ptr_shift_in           (wr_ptr_shift_in),
		.ptr_flags_in              (ptr_flags_in),
		.two_apart_alarm_enable_in (ena[0]),
		.one_apart_alarm_enable_in (ena[1]),
		.collision_alarm_enable_in (ena[2]),
		.conv_clk_tick_in          (tick),
		.interp_in                 (interp_in),
		.lane_enable_out           (lane_en),
		.trim_out                  (trim),
		.ext_ref_out               (ext_ref),
		.alt_clk_sel_out           (alt_clk)
	);

	task automatic chk(input string n, input logic [15:0] e, logic [15:0] g);
		checks++;
		if (g !== e) begin
			n_errors++;
			$display("Error %s expected %h seen %h", n, e, g);
		end
	endtask : chk

	task automatic rchk(input string n, input logic [6:0] a, logic [15:0] e);
		logic [15:0] d;
		u_dac_host_model.read_word(a, d);
		chk(n, e, d);
	endtask : rchk

	task automatic wr(input logic [6:0] a, input logic [15:0] d);
		u_dac_host_model.write_word(a, d);
	endtask : wr

	task automatic cyc(input int n);
		repeat (n) @(posedge clk_in);
		#1;
	endtask : cyc

	task automatic send(input logic s, input logic [13:0] v);
		cyc(1);
		sync_in = s;
		sample_valid_in = 1'b1;
		sample_in = v;
		cyc(1);
		sync_in = 1'b0;
		sample_valid_in = 1'b0;
	endtask : send

	task automatic summarize();
		$display("Checks %0d mismatches %0d", checks, n_errors);
		if (n_errors == 0 && checks > 0)
			$display("Result: passed");
		else
			$display("Result: failed");
		$finish;
	endtask : summarize

	initial begin
		#50us;
		n_errors++;
		summarize();
	end

	initial begin
		for (int k = 0; k < 8; k++)
			pat[k] = 14'(k * 14'h0123 + 14'h0a5c);
		// Status words have no reset value: clear them while reset holds
		wr(`ADDR_PATT, 16'h0000);
		wr(`ADDR_ALARM, 16'h0000);
		srst_in = 1'b0;
		chk("lane_enable_out", 16'h3fff, {2'h0, lane_en});
		rchk("lane_word", `ADDR_LANE_EN, 16'h3fff);
		rchk("trim_word", `ADDR_TRIM, 16'h0000);
		rchk("unmapped", 7'h07, 16'h0000);
		rchk("patt_init", `ADDR_PATT, 16'h0000);
		wr(7'h01, 16'hffff);
		rchk("lane_kept", `ADDR_LANE_EN, 16'h3fff);
		wr(`ADDR_LANE_EN, 16'hff80);
		rchk("lane_word", `ADDR_LANE_EN, 16'h3f80);
		chk("lane_enable_out", 16'h3f80, {2'h0, lane_en});
		$display("Test reset_and_lanes done");
		foreach (tv[i]) begin
			wr(`ADDR_TRIM, tv[i]);
			rchk("trim_word", `ADDR_TRIM, tv[i] & 16'hfff9);
			chk("trim_out", {4'h0, tv[i][15:4]}, {4'h0, trim});
			chk("ref_clk_sel", {14'h0, tv[i][3], tv[i][0]},
				{14'h0, ext_ref, alt_clk});
		end
		wr(`ADDR_TRIM, 16'h0000);
		chk("alt_clk_sel", 16'h0000, {15'h0, alt_clk});
		$display("Test trims done");
		send(1'b1, ~pat[0]);
		rchk("patt_off", `ADDR_PATT, 16'h0000);
		iotest_enable_in = 1'b1;
		send(1'b1, pat[0] ^ 14'h0001);
		send(1'b0, pat[1] ^ 14'h2000);
		send(1'b0, pat[2]);
		rchk("patt_res", `ADDR_PATT, 16'h2001);
		cyc(1);
		srst_in = 1'b1;
		cyc(2);
		srst_in = 1'b0;
		rchk("patt_kept", `ADDR_PATT, 16'h2001);
		wr(`ADDR_PATT, 16'h0001);
		rchk("patt_wc", `ADDR_PATT, 16'h0001);
		wr(`ADDR_PATT, 16'h0000);
		rchk("patt_clr", `ADDR_PATT, 16'h0000);
		iotest_enable_in = 1'b0;
		$display("Test pattern done");
		for (int i = 0; i < 4; i++) begin
			for (int e = 1; e >= 0; e--) begin
				ena = e ? 3'h7 : 3'h0;
				if (i == 3)
					ena = 3'(e * 3);
				cyc(1);
				ptr_flags_in = (i == 3) ? 3'h7 : 3'(1 << i);
				cyc(1);
				ptr_flags_in = '0;
				rchk("ptr_code", `ADDR_ALARM,
					e ? 16'(1 << (11 + i % 3 + i / 3)) : 16'h0);
				wr(`ADDR_ALARM, 16'h0000);
			end
		end
		ena = 3'h7;
		$display("Test pointer_codes done");
		cyc(1);
		wr_ptr_shift_in = 8'h00;
		cyc(1);
		wr_ptr_shift_in = 8'h01;
		rchk("stuck_ptr", `ADDR_ALARM, 16'h8000);
		// Resync is modelled by restoring a one in the shift register
		wr(`ADDR_ALARM, 16'h8000);
		rchk("stuck_kept", `ADDR_ALARM, 16'h8000);
		wr(`ADDR_ALARM, 16'h0000);
		cyc(20);
		rchk("clk_running", `ADDR_ALARM, 16'h0000);
		tick = 1'b0;
		cyc(10);
		rchk("clk_gone", `ADDR_ALARM, 16'h0080);
		tick = 1'b1;
		wr(`ADDR_ALARM, 16'h0000);
		rchk("clk_clear", `ADDR_ALARM, 16'h0000);
		interp_in = 2'h2;
		tick = 1'b0;
		cyc(6);
		rchk("clk_slow", `ADDR_ALARM, 16'h0000);
		cyc(4);
		rchk("clk_gone_slow", `ADDR_ALARM, 16'h0080);
		tick = 1'b1;
		wr(`ADDR_ALARM, 16'h0000);
		$display("Test alarms done");
		summarize();
	end
endmodule : dac_input_regs_tb
